/* File: rtl/dbg_scan_pkg.sv */
// Constants, field layouts and types for the debug-port scan response block
// Contract
// - Acknowledge OK or FAULT only once the previously issued transaction has completed.
// - After a read completed OK, the captured result field holds the read value.
// - After OK or FAULT, Update-DR issues the shifted request to the selected port.
// - Read bit zero writes the write-data field into the addressed register.
// - Read bit one ignores write data, starts a read; another scan fetches it.
// - Each scan returns the prior read result; read buffer yields the last one.
// - Reading the read buffer register changes nothing in the tap state machine.
// - Access-port request with any sticky flag set is dropped; next scan gets FAULT.
// - Pushed mode issues a read and compares against write data, updating compare flag.
// - Transfer-mode field in control/status enables pushed compare and pushed verify.
// - An access-port transaction stays open until the access port reports done.
// - WAIT is returned while the previous transaction is still incomplete.
// - Debug-port accesses answer WAIT until every earlier access-port transaction ends.
// - An abort request makes the access port release its interface at once.
// - After WAIT no request is issued at Update-DR and shifted data is dropped.
// - Sticky overrun is set on every FAULT, and on a busy WAIT when overrun detect is one.
// - With overrun set: WAIT while busy, then FAULT for every access-port scan.
// - With overrun set, debug-port scans still answer OK; writing one clears it.
// - Capture-DR too soon after Update-DR answers WAIT immediately.
// - Capture-DR loads result plus 3-bit acknowledge, shifted out LSB first.
// - Acknowledge codes: WAIT 001, FAULT 010, OK 100; others reserved.
// - A busy WAIT sets sticky overrun only when overrun detect is one.
`default_nettype none
package dbg_scan_pkg;
	// Scan chain layout
	localparam int CHAIN_W = 35;
	localparam int RD_BIT  = 0;
	localparam int ADDR_LO = 1;
	localparam int ADDR_HI = 2;
	localparam int DATA_LO = 3;
	localparam int DATA_HI = 34;
	localparam int ACK_HI  = 2;
	// Acknowledge encodings
	localparam logic [2:0] ACK_WAIT  = 3'h1;
	localparam logic [2:0] ACK_FAULT = 3'h2;
	localparam logic [2:0] ACK_OK    = 3'h4;
	// Instruction codes seen on the instruction input
	localparam logic [3:0] IR_DBG_ACC  = 4'ha;
	localparam logic [3:0] IR_PORT_ACC = 4'hb;
	localparam logic [3:0] IR_BYPASS   = 4'hf;
	// Debug-port register addresses within the chain
	localparam logic [1:0] DA_ID     = 2'h0;
	localparam logic [1:0] DA_CTRL   = 2'h1;
	localparam logic [1:0] DA_SELECT = 2'h2;
	localparam logic [1:0] DA_RDBUF  = 2'h3;
	// Control/status layout
	localparam int CS_W       = 6;
	localparam int CS_ORUN_DET = 0;
	localparam int CS_ORUN    = 1;
	localparam int CS_TRN_LO  = 2;
	localparam int CS_TRN_HI  = 3;
	localparam int CS_CMP     = 4;
	localparam int CS_ERR     = 5;
	localparam logic [CS_W-1:0] STICKY_MASK = 6'h32;
	localparam logic [CS_W-1:0] CS_RESET    = 6'h00;
	// Transfer modes
	localparam logic [1:0] TRN_NORMAL  = 2'h0;
	localparam logic [1:0] TRN_VERIFY  = 2'h1;
	localparam logic [1:0] TRN_COMPARE = 2'h2;
	// Update-to-capture gap counter
	localparam int GAP_W = 8;
	localparam logic [GAP_W-1:0] GAP_MIN_RESET = 8'h04;
	localparam logic [GAP_W-1:0] GAP_SAT       = 8'hff;
	// Register bus map
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] REG_GAP    = 8'h00;
	localparam logic [APB_AW-1:0] REG_CTRL   = 8'h04;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [APB_AW-1:0] REG_RESULT = 8'h0c;
	// Scan status layout
	localparam int ST_ACK_HI = 2;
	localparam int ST_BUSY   = 3;
	localparam int ST_PFAULT = 4;
	// Identification value returned by the id register, arbitrary
	localparam logic [31:0] DBG_ID_VALUE = 32'h1234_5671;
	// Access-port transaction tracking
	typedef enum logic [0:0] {
		XP_IDLE = 1'b0,
		XP_BUSY = 1'b1
	} xact_state_t;
endpackage
`default_nettype wire

/* File: rtl/dbg_scan_resp.sv */
// Debug-port access scan chain: acknowledge, pipelined results and request issue
`default_nettype none
module dbg_scan_resp (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// Register bus
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Scan side, from the tap and debugger
	input  wire logic        tck,
	input  wire logic        debug_serial_in,
	output logic             debug_serial_out,
	input  wire logic        tap_capture_dr,
	input  wire logic        tap_shift_dr,
	input  wire logic        tap_update_dr,
	input  wire logic [3:0]  tap_ir,
	input  wire logic        abort_req,
	// Access port side
	output logic             tgt_req,
	output logic             tgt_write,
	output logic      [1:0]  tgt_addr,
	output logic      [31:0] tgt_wdata,
	input  wire logic [31:0] tgt_rdata,
	input  wire logic        tgt_done,
	input  wire logic        tgt_error,
	output logic             tgt_abort
);

	typedef struct packed {
		logic        tck_m;
		logic        tck_s;
		logic        tck_d;
		logic        tdi_m;
		logic        tdi_s;
		logic        cap_m;
		logic        cap_s;
		logic        sh_m;
		logic        sh_s;
		logic        upd_m;
		logic        upd_s;
		logic        abt_m;
		logic        abt_s;
		logic        abt_d;
		logic [3:0]  ir_m;
		logic [3:0]  ir_s;
		logic [34:0] chain;
		logic        tdo;
		logic [2:0]  ack;
		dbg_scan_pkg::xact_state_t xst;
		logic        pend_fault;
		logic        pushed;
		logic        rd_op;
		logic [1:0]  trn;
		logic [31:0] cmp_data;
		logic [31:0] result;
		logic [7:0]  gap;
		logic [7:0]  gap_min;
		logic [5:0]  ctrl;
		logic [31:0] select;
		logic        req;
		logic        wr;
		logic [1:0]  addr;
		logic [31:0] wdata;
		logic        abort;
		logic [31:0] rdata;
	} state_t;

	localparam state_t ST_RESET = '{
		xst:     dbg_scan_pkg::XP_IDLE,
		gap_min: dbg_scan_pkg::GAP_MIN_RESET,
		ctrl:    dbg_scan_pkg::CS_RESET,
		default: '0
	};

	state_t st_r;
	state_t st_nxt;

	logic        tck_rise;
	logic        tck_fall;
	logic        is_dbg;
	logic        is_port;
	logic        is_bypass;
	logic        do_capture;
	logic        do_shift;
	logic        do_update;
	logic [2:0]  ack_v;
	logic [5:0]  sticky_set;
	logic [5:0]  sticky_clr;
	logic        rd_bit;
	logic [1:0]  ch_addr;
	logic [31:0] ch_data;
	logic        bus_setup;
	logic        bus_write;
	logic        bus_hit;
	logic        match;

	// Bus decode, answered in the first access cycle
	assign bus_setup = psel & ~penable;
	assign bus_write = psel & penable & pwrite;
	assign bus_hit   = (paddr == dbg_scan_pkg::REG_GAP) | (paddr == dbg_scan_pkg::REG_CTRL) |
			   (paddr == dbg_scan_pkg::REG_STATUS) | (paddr == dbg_scan_pkg::REG_RESULT);
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~bus_hit;

	// Outputs straight from state
	assign prdata           = st_r.rdata;
	assign debug_serial_out = st_r.tdo;
	assign tgt_req          = st_r.req;
	assign tgt_write        = st_r.wr;
	assign tgt_addr         = st_r.addr;
	assign tgt_wdata        = st_r.wdata;
	assign tgt_abort        = st_r.abort;

	// Next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;
		ack_v = dbg_scan_pkg::ACK_OK;
		sticky_set = '0;
		sticky_clr = '0;
		match = 1'b0;
		// Two-flop synchronisers for everything arriving from the tap domain
		st_nxt.tck_m = tck;
		st_nxt.tck_s = st_r.tck_m;
		st_nxt.tck_d = st_r.tck_s;
		st_nxt.tdi_m = debug_serial_in;
		st_nxt.tdi_s = st_r.tdi_m;
		st_nxt.cap_m = tap_capture_dr;
		st_nxt.cap_s = st_r.cap_m;
		st_nxt.sh_m = tap_shift_dr;
		st_nxt.sh_s = st_r.sh_m;
		st_nxt.upd_m = tap_update_dr;
		st_nxt.upd_s = st_r.upd_m;
		st_nxt.abt_m = abort_req;
		st_nxt.abt_s = st_r.abt_m;
		st_nxt.abt_d = st_r.abt_s;
		st_nxt.ir_m = tap_ir;
		st_nxt.ir_s = st_r.ir_m;
		st_nxt.req = 1'b0;
		st_nxt.abort = 1'b0;

		tck_rise = st_r.tck_s & ~st_r.tck_d;
		tck_fall = ~st_r.tck_s & st_r.tck_d;
		is_dbg = st_r.ir_s == dbg_scan_pkg::IR_DBG_ACC;
		is_port = st_r.ir_s == dbg_scan_pkg::IR_PORT_ACC;
		is_bypass = st_r.ir_s == dbg_scan_pkg::IR_BYPASS;
		do_capture = tck_rise & st_r.cap_s;
		do_shift = tck_rise & st_r.sh_s;
		do_update = tck_rise & st_r.upd_s & (is_dbg | is_port);
		rd_bit = st_r.chain[dbg_scan_pkg::RD_BIT];
		ch_addr = st_r.chain[dbg_scan_pkg::ADDR_HI:dbg_scan_pkg::ADDR_LO];
		ch_data = st_r.chain[dbg_scan_pkg::DATA_HI:dbg_scan_pkg::DATA_LO];

		// Count tap cycles since the last update not answered WAIT, saturating
		if (tck_rise && st_r.gap != dbg_scan_pkg::GAP_SAT) begin
			st_nxt.gap = st_r.gap + 8'h01;
		end

		// Capture: choose the acknowledge and load result above it
		if (do_capture && (is_dbg || is_port)) begin
			if (st_r.gap < st_r.gap_min) begin
				ack_v = dbg_scan_pkg::ACK_WAIT;
			end else if (st_r.xst == dbg_scan_pkg::XP_BUSY) begin
				ack_v = dbg_scan_pkg::ACK_WAIT;
				if (st_r.ctrl[dbg_scan_pkg::CS_ORUN_DET]) begin
					sticky_set[dbg_scan_pkg::CS_ORUN] = 1'b1;
				end
			end else if (st_r.pend_fault) begin
				ack_v = dbg_scan_pkg::ACK_FAULT;
				st_nxt.pend_fault = 1'b0;
			end else if (is_port && st_r.ctrl[dbg_scan_pkg::CS_ORUN]) begin
				ack_v = dbg_scan_pkg::ACK_FAULT;
			end else begin
				ack_v = dbg_scan_pkg::ACK_OK;
			end
			if (ack_v == dbg_scan_pkg::ACK_FAULT) begin
				sticky_set[dbg_scan_pkg::CS_ORUN] = 1'b1;
			end
			st_nxt.ack = ack_v;
			// Result above the acknowledge, acknowledge leaves first
			st_nxt.chain = {st_r.result, ack_v};
		end else if (do_capture && is_bypass) begin
			st_nxt.chain[0] = 1'b0;
		end

		// Shift: least significant bit leaves, new bit enters at the top
		if (do_shift && is_bypass) begin
			st_nxt.chain[0] = st_r.tdi_s;
		end else if (do_shift && (is_dbg || is_port)) begin
			st_nxt.chain = {st_r.tdi_s, st_r.chain[dbg_scan_pkg::DATA_HI:1]};
		end

		// Serial out changes on the falling tap clock edge
		if (tck_fall) begin
			st_nxt.tdo = st_r.chain[0];
		end

		// Update: issue the request unless the scan was answered WAIT or, for an access-port scan, a sticky flag is set
		if (do_update) begin
			st_nxt.gap = '0;
			if (st_r.ack == dbg_scan_pkg::ACK_WAIT) begin
				st_nxt.gap = st_r.gap;
			end else if (is_dbg) begin
				// Debug-port register access, completes at once
				case (ch_addr)
					dbg_scan_pkg::DA_ID: begin
						if (rd_bit) begin
							st_nxt.result = dbg_scan_pkg::DBG_ID_VALUE;
						end
					end
					dbg_scan_pkg::DA_CTRL: begin
						if (rd_bit) begin
							st_nxt.result = {26'h0, st_r.ctrl};
						end else begin
							st_nxt.ctrl[dbg_scan_pkg::CS_ORUN_DET] =
								ch_data[dbg_scan_pkg::CS_ORUN_DET];
							st_nxt.ctrl[dbg_scan_pkg::CS_TRN_HI:dbg_scan_pkg::CS_TRN_LO] =
								ch_data[dbg_scan_pkg::CS_TRN_HI:dbg_scan_pkg::CS_TRN_LO];
							sticky_clr = ch_data[5:0] & dbg_scan_pkg::STICKY_MASK;
						end
					end
					dbg_scan_pkg::DA_SELECT: begin
						if (rd_bit) begin
							st_nxt.result = '0;
						end else begin
							st_nxt.select = ch_data;
						end
					end
					dbg_scan_pkg::DA_RDBUF: begin
						st_nxt.result = st_r.result;
					end
					default: begin
						st_nxt.result = st_r.result;
					end
				endcase
			end else if ((st_r.ctrl & dbg_scan_pkg::STICKY_MASK) != '0) begin
				st_nxt.pend_fault = 1'b1;
			end else begin
				// Access-port request, pushed modes force a read
				st_nxt.trn = st_r.ctrl[dbg_scan_pkg::CS_TRN_HI:dbg_scan_pkg::CS_TRN_LO];
				st_nxt.pushed = st_nxt.trn != dbg_scan_pkg::TRN_NORMAL;
				st_nxt.rd_op = rd_bit | st_nxt.pushed;
				st_nxt.req = 1'b1;
				st_nxt.wr = ~st_nxt.rd_op;
				st_nxt.addr = ch_addr;
				st_nxt.wdata = ch_data;
				st_nxt.cmp_data = ch_data;
				st_nxt.xst = dbg_scan_pkg::XP_BUSY;
			end
		end

		// Completion from the access port closes the transaction
		if (st_r.xst == dbg_scan_pkg::XP_BUSY && tgt_done) begin
			st_nxt.xst = dbg_scan_pkg::XP_IDLE;
			match = tgt_rdata == st_r.cmp_data;
			if (tgt_error) begin
				sticky_set[dbg_scan_pkg::CS_ERR] = 1'b1;
			end else if (st_r.pushed) begin
				// Verify flags a mismatch, compare flags a match
				if ((st_r.trn == dbg_scan_pkg::TRN_VERIFY && !match) ||
				    (st_r.trn == dbg_scan_pkg::TRN_COMPARE && match)) begin
					sticky_set[dbg_scan_pkg::CS_CMP] = 1'b1;
				end
			end else if (st_r.rd_op) begin
				st_nxt.result = tgt_rdata;
			end
		end

		// Abort frees the transaction tracking regardless of the far side
		if (st_r.abt_s && !st_r.abt_d) begin
			st_nxt.abort = 1'b1;
			st_nxt.xst = dbg_scan_pkg::XP_IDLE;
		end

		// Register bus writes
		if (bus_write && paddr == dbg_scan_pkg::REG_GAP) begin
			st_nxt.gap_min = pwdata[7:0];
		end
		if (bus_write && paddr == dbg_scan_pkg::REG_CTRL) begin
			st_nxt.ctrl[dbg_scan_pkg::CS_ORUN_DET] = pwdata[dbg_scan_pkg::CS_ORUN_DET];
			st_nxt.ctrl[dbg_scan_pkg::CS_TRN_HI:dbg_scan_pkg::CS_TRN_LO] =
				pwdata[dbg_scan_pkg::CS_TRN_HI:dbg_scan_pkg::CS_TRN_LO];
			sticky_clr = sticky_clr | (pwdata[5:0] & dbg_scan_pkg::STICKY_MASK);
		end

		// Sticky flags: a set in the same cycle as a clear wins
		st_nxt.ctrl = (st_nxt.ctrl & ~sticky_clr) | sticky_set;

		// Register bus read data, loaded in the setup cycle
		if (bus_setup) begin
			case (paddr)
				dbg_scan_pkg::REG_GAP: st_nxt.rdata = {24'h0, st_r.gap_min};
				dbg_scan_pkg::REG_CTRL: st_nxt.rdata = {26'h0, st_r.ctrl};
				dbg_scan_pkg::REG_STATUS: st_nxt.rdata = {27'h0, st_r.pend_fault,
						st_r.xst == dbg_scan_pkg::XP_BUSY, st_r.ack};
				dbg_scan_pkg::REG_RESULT: st_nxt.rdata = st_r.result;
				default: st_nxt.rdata = '0;
			endcase
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_RESET;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

/* File: testbench/dbg_scan_resp_checker.sv */
// Port assertions for the debug scan response block
`default_nettype none
module dbg_scan_resp_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tck,
	input wire logic        debug_serial_out,
	input wire logic        tgt_req,
	input wire logic        tgt_write,
	input wire logic [1:0]  tgt_addr,
	input wire logic [31:0] tgt_wdata,
	input wire logic        tgt_done,
	input wire logic        tgt_abort
);
	logic       acc;
	logic       mapped;
	logic       busy_r;
	logic       tck_r;
	logic [3:0] fall_cnt_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and address decode
	assign acc    = psel && penable;
	assign mapped = paddr inside {dbg_scan_pkg::REG_GAP, dbg_scan_pkg::REG_CTRL,
		dbg_scan_pkg::REG_STATUS, dbg_scan_pkg::REG_RESULT};
	// Outstanding request and cycles since the last tck fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r     <= 1'b0;
			tck_r      <= 1'b0;
			fall_cnt_r <= 4'hf;
		end else begin
			busy_r     <= tgt_req || (busy_r && !tgt_done && !tgt_abort);
			tck_r      <= tck;
			fall_cnt_r <= (tck_r && !tck) ? 4'h0 : fall_cnt_r + {3'h0, fall_cnt_r != 4'hf};
		end
	end
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (acc && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_unmapped_zero: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_req_pulse: assert property (tgt_req |=> !tgt_req)
		else $error("request longer than one cycle");
	a_abort_pulse: assert property (tgt_abort |=> !tgt_abort)
		else $error("abort longer than one cycle");
	a_fields_hold: assert property (!tgt_req |-> $stable({tgt_write, tgt_addr, tgt_wdata}))
		else $error("request fields moved without request");
	a_one_outstanding: assert property (busy_r && !tgt_done |-> !tgt_req)
		else $error("request issued while one is open");
	a_out_after_fall: assert property ($changed(debug_serial_out) |-> fall_cnt_r < 4'h9)
		else $error("serial out moved away from a tck fall");
endmodule
bind dbg_scan_resp dbg_scan_resp_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tck(tck), .debug_serial_out(debug_serial_out), .tgt_req(tgt_req),
	.tgt_write(tgt_write), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_done(tgt_done),
	.tgt_abort(tgt_abort));
`default_nettype wire

/* File: testbench/dbg_probe.sv */
// Debugger probe model that clocks access scans into the tap inputs
`default_nettype none
module dbg_probe (
	output logic       tck,
	output logic       tap_capture_dr,
	output logic       tap_shift_dr,
	output logic       tap_update_dr,
	output logic [3:0] tap_ir,
	output logic       debug_serial_in,
	input  wire logic  debug_serial_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle levels; tck stands still between scans
	initial begin
		{tck, tap_capture_dr, tap_shift_dr, tap_update_dr} = 4'h0;
		tap_ir = 4'hf;
		debug_serial_in = 1'b0;
	end
	// One tck period; serial out is taken at the rise, where it is settled
	task automatic tick(output logic so);
		#62.5 tck = 1'b1;
		so = debug_serial_out;
		#62.5 tck = 1'b0;
	endtask
	// Capture, shift 35 bits LSB first, update, then pad idle cycles
	task automatic scan(input logic [3:0] ir, input logic [34:0] din, input int pad,
		output logic [34:0] dout);
		logic so;
		tap_ir = ir;
		tap_capture_dr = 1'b1;
		tick(so);
		tap_capture_dr = 1'b0;
		tap_shift_dr = 1'b1;
		for (int i = 0; i < 35; i++) begin
			debug_serial_in = din[i];
			tick(so);
			dout[i] = so;
		end
		tap_shift_dr = 1'b0;
		debug_serial_in = ~debug_serial_in; // Released line shows no stale bit
		tap_update_dr = 1'b1;
		tick(so);
		tap_update_dr = 1'b0;
		repeat (pad) tick(so);
	endtask
endmodule
`default_nettype wire

/* File: testbench/dbg_scan_resp_tb_top.sv */
// Testbench top for the debug scan response block
`default_nettype none
module dbg_scan_resp_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0]  DA = dbg_scan_pkg::IR_DBG_ACC;
	localparam logic [3:0]  PA = dbg_scan_pkg::IR_PORT_ACC;
	localparam logic [2:0]  OK = dbg_scan_pkg::ACK_OK;
	localparam logic [2:0]  WT = dbg_scan_pkg::ACK_WAIT;
	localparam logic [2:0]  FT = dbg_scan_pkg::ACK_FAULT;
	localparam logic [7:0]  RC = dbg_scan_pkg::REG_CTRL;
	localparam logic [31:0] AV = 32'hc0de_5a00;
	logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat, tgt_wdata, tgt_rdata = 32'h0;
	logic        pready, pslverr, err, tck, tdi, tdo, cap, shf, upd, abort_req = 1'b0;
	logic        tgt_req, tgt_write, tgt_done = 1'b0, tgt_abort, pend = 1'b0;
	logic [1:0]  tgt_addr;
	logic [3:0]  ir;
	logic [34:0] so;
	int          fail_count = 0, cmp_count = 0, req_count = 0, abort_cnt = 0;
	int          ap_delay = 3, wcnt = 0, n;
	dbg_scan_resp dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tck(tck), .debug_serial_in(tdi),
		.debug_serial_out(tdo), .tap_capture_dr(cap), .tap_shift_dr(shf), .tap_update_dr(upd),
		.tap_ir(ir), .abort_req(abort_req), .tgt_req(tgt_req), .tgt_write(tgt_write),
		.tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata), .tgt_done(tgt_done),
		.tgt_error(1'b0), .tgt_abort(tgt_abort));
	dbg_probe probe (.tck(tck), .tap_capture_dr(cap), .tap_shift_dr(shf), .tap_update_dr(upd),
		.tap_ir(ir), .debug_serial_in(tdi), .debug_serial_out(tdo));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Access port: answers ap_delay+1 cycles after taking the request, drops the request on abort
	always @(posedge pclk) begin
		tgt_done  <= pend && wcnt == 0 && !tgt_abort;
		tgt_rdata <= (pend && wcnt == 0) ? AV | 32'(tgt_addr) : ~tgt_rdata;
		if (tgt_abort) begin
			pend <= 1'b0;
			abort_cnt <= abort_cnt + 1;
		end else if (tgt_req) begin
			pend <= 1'b1;
			wcnt <= ap_delay;
			req_count <= req_count + 1;
		end else if (pend) begin
			pend <= wcnt != 0;
			wcnt <= wcnt - 1;
		end
	end
	task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One register bus transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One access scan; the acknowledge is compared unless ack is zero
	task automatic xs(input logic [3:0] i, input logic read_not_write_bit, input logic [1:0] a,
		input logic [31:0] d, input int pad, input logic [2:0] ack);
		probe.scan(i, {d, a, read_not_write_bit}, pad, so);
		if (ack !== 3'h0) chk({32'h0, so[2:0]}, {32'h0, ack});
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		#400us;
		fail_count++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, dbg_scan_pkg::REG_GAP, 0);
		chk(35'(rdat), 35'h4);
		apb(0, RC, 0);
		chk(35'(rdat), 35'h0);
		apb(0, 8'h10, 0);
		chk({2'h0, err, rdat}, {3'h1, 32'h0});
		// Pipelined debug-port reads through the read buffer
		xs(DA, 1, 2'h0, 0, 4, WT);
		xs(DA, 1, 2'h0, 0, 4, OK);
		xs(DA, 1, 2'h3, 0, 4, OK);
		chk(35'(so[34:3]), 35'(dbg_scan_pkg::DBG_ID_VALUE));
		xs(DA, 1, 2'h3, 0, 4, OK);
		chk(35'(so[34:3]), 35'(dbg_scan_pkg::DBG_ID_VALUE));
		// Access-port write then pipelined reads
		xs(PA, 0, 2'h1, 32'h5a5a_0f0f, 4, OK);
		chk({tgt_write, tgt_addr, tgt_wdata}, {3'h5, 32'h5a5a_0f0f});
		xs(PA, 1, 2'h2, 32'hffff_ffff, 4, OK);
		chk(35'({tgt_write, tgt_addr}), 35'h2);
		xs(PA, 1, 2'h0, 0, 4, OK);
		chk(35'(so[34:3]), 35'(AV | 32'h2));
		xs(DA, 1, 2'h3, 0, 4, OK);
		chk(35'(so[34:3]), 35'(AV));
		// Capture too soon after update
		xs(DA, 1, 2'h0, 0, 0, OK);
		xs(DA, 1, 2'h0, 0, 4, WT);
		xs(DA, 1, 2'h0, 0, 4, OK);
		// Slow access port, then overrun detection and recovery
		ap_delay = 1000;
		xs(PA, 1, 2'h1, 0, 4, OK);
		n = req_count;
		xs(PA, 1, 2'h2, 0, 4, WT);
		chk(35'(req_count), 35'(n));
		apb(0, RC, 0);
		chk(35'(rdat[1]), 35'h0);
		apb(1, RC, 32'h1);
		xs(DA, 1, 2'h0, 0, 4, WT);
		apb(0, RC, 0);
		chk(35'(rdat[1]), 35'h1);
		while (pend) @(posedge pclk);
		xs(PA, 1, 2'h2, 0, 4, FT);
		chk(35'(req_count), 35'(n));
		xs(DA, 1, 2'h1, 0, 4, FT);
		xs(DA, 0, 2'h1, 32'h2, 4, OK);
		chk(35'(so[4:3]), 35'h3);
		apb(0, RC, 0);
		chk(35'(rdat[1:0]), 35'h0);
		// Pushed compare sets the compare flag, which then blocks the port
		ap_delay = 3;
		apb(1, RC, 32'h3a);
		xs(PA, 0, 2'h3, AV | 32'h3, 4, OK);
		chk(35'(tgt_write), 35'h0);
		xs(DA, 1, 2'h0, 0, 4, OK);
		apb(0, RC, 0);
		chk(35'(rdat[4]), 35'h1);
		n = req_count;
		xs(PA, 0, 2'h0, 0, 4, OK);
		chk(35'(req_count), 35'(n));
		xs(DA, 1, 2'h0, 0, 4, FT);
		// Abort frees the port while a transfer hangs
		apb(1, RC, 32'h32);
		ap_delay = 100000;
		xs(PA, 1, 2'h0, 0, 4, OK);
		@(posedge pclk);
		abort_req <= 1'b1;
		repeat (8) @(posedge pclk);
		abort_req <= 1'b0;
		chk(35'({abort_cnt, pend}), 35'h2);
		end_of_test();
	end
endmodule
`default_nettype wire
